// >>> inc/button_pkg.sv
package button_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 125_000_000;
  localparam int NUM_BUTTONS   = 4;
  localparam int CNT_WIDTH     = 8;
  // Tick period in microseconds and the blanking time in milliseconds.
  localparam int TICK_US       = 1000;
  localparam int BLANK_MS      = 180;
  localparam int TICK_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * TICK_US;
  localparam int PRESET_TICKS  = (BLANK_MS * 1000) / TICK_US;
  localparam int DIV_WIDTH     = 32;

  typedef logic [CNT_WIDTH-1:0]   count_t;
  typedef logic [NUM_BUTTONS-1:0] btn_t;

  localparam count_t CNT_ZERO   = count_t'(0);
  localparam count_t CNT_ONE    = count_t'(1);
  localparam count_t CNT_PRESET = count_t'(PRESET_TICKS);
  localparam btn_t   BTN_NONE   = btn_t'(0);

endpackage : button_pkg

// >>> hw/tick_divider.sv
`timescale 1ns/1ns
module tick_divider
#(
  parameter int TICK_CYCLES = button_pkg::TICK_CYCLES
)
(
  input  wire logic clk,     // System clock.
  input  wire logic sys_rst, // Synchronous reset, active high.
  output logic      tick     // One-cycle enable pulse per period.
);
  import button_pkg::*;

  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] div_next;
  wire                  atEnd = (div_reg == DIV_WIDTH'(TICK_CYCLES - 1));

  assign div_next = atEnd ? '0 : div_reg + DIV_WIDTH'(1);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick    <= atEnd;
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick)
    else $error("tick lasted more than one cycle");

endmodule : tick_divider

// >>> hw/button_debounce_latch.sv
`timescale 1ns/1ns
module button_debounce_latch
#(
  parameter int TICK_CYCLES = button_pkg::TICK_CYCLES
)
(
  input  wire logic                    clk,             // System clock.
  input  wire logic                    sys_rst,         // Synchronous reset, active high.
  input  wire logic                    run_stop_input,  // Run/stop switch pin.
  input  wire button_pkg::btn_t        buttonPin_n,     // Button pins, low when pressed.
  input  wire button_pkg::btn_t        press_query,     // One-cycle query per button.
  output logic                         runStopLevel,    // Synchronised switch level.
  output button_pkg::btn_t             queryResult,     // Query answer, one cycle later.
  output button_pkg::btn_t             press_latched,   // Latched press bits.
  output logic                         scanEnabled      // High while scanning runs.
);
  import button_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic  rsMeta_reg;
  btn_t  btnMeta_reg;
  btn_t  btnSync_reg;

  // The chains reset to the released level, so no false press follows reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsMeta_reg   <= 1'b1;
      runStopLevel <= 1'b1;
      btnMeta_reg  <= ~BTN_NONE;
      btnSync_reg  <= ~BTN_NONE;
    end
    else
    begin
      rsMeta_reg   <= run_stop_input;
      runStopLevel <= rsMeta_reg;
      btnMeta_reg  <= buttonPin_n;
      btnSync_reg  <= btnMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Periodic tick
  // ----------------------------------------------------------------
  logic debounce_tick_handler;

  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_div
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (debounce_tick_handler)
  );

  // ----------------------------------------------------------------
  // Scan and blanking
  // ----------------------------------------------------------------
  count_t cnt_reg;
  count_t cnt_next;
  btn_t   latch_next;
  wire    scanSample = debounce_tick_handler & (cnt_reg == CNT_ZERO);
  wire    btn_t pressSeen = scanSample ? ~btnSync_reg : BTN_NONE;
  wire    anyPress  = |pressSeen;
  wire    btn_t clearHit  = press_query & press_latched;

  // A press seen at a scan tick loads the full count, so release bounce stays hidden.
  // blank scan, load preset
  assign cnt_next = anyPress ? CNT_PRESET :
                    (debounce_tick_handler && cnt_reg != CNT_ZERO) ? cnt_reg - CNT_ONE :
                    cnt_reg;
  assign latch_next  = (press_latched & ~clearHit) | pressSeen;
  assign scanEnabled = (cnt_reg == CNT_ZERO);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_reg       <= CNT_ZERO;
      press_latched <= BTN_NONE;
      queryResult   <= BTN_NONE;
    end
    else
    begin
      cnt_reg       <= cnt_next;
      press_latched <= latch_next;
      queryResult   <= clearHit;
    end
  end

  // ----------------------------------------------------------------
  // Blanking length monitor
  // ----------------------------------------------------------------
  // Counts the cycles of one blanking interval for blank_len_a.
  int unsigned blankLen_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst || anyPress)
    begin
      blankLen_reg <= '0;
    end
    else if (!scanEnabled)
    begin
      blankLen_reg <= blankLen_reg + 1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  load_preset_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyPress |=> cnt_reg == CNT_PRESET)
    else $error("preset not loaded after press");

  blank_scan_a: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg != CNT_ZERO |=> (press_latched & ~$past(press_latched)) == BTN_NONE)
    else $error("press latched while blanked");

  count_down_a: assert property (@(posedge clk) disable iff (sys_rst)
    (debounce_tick_handler && cnt_reg != CNT_ZERO && !anyPress)
      |=> cnt_reg == $past(cnt_reg) - CNT_ONE)
    else $error("counter did not step on tick");

  hold_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    !debounce_tick_handler |=> $stable(cnt_reg))
    else $error("counter moved without tick");

  // ----------------------------------------------------------------
  // Per-button checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_BUTTONS; g++)
  begin : g_btnChk
    press_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      scanSample && !btnSync_reg[g] |=> press_latched[g])
      else $error("press not latched");

    no_stray_a: assert property (@(posedge clk) disable iff (sys_rst)
      !pressSeen[g] && !press_latched[g] |=> !press_latched[g])
      else $error("press bit set without a scan");

    latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      press_latched[g] && !press_query[g] |=> press_latched[g])
      else $error("press bit lost without a query");

    query_one_a: assert property (@(posedge clk) disable iff (sys_rst)
      press_query[g] && press_latched[g] && !pressSeen[g]
        |=> queryResult[g] && !press_latched[g])
      else $error("query did not return and clear");

    query_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      press_query[g] && !press_latched[g] && !pressSeen[g]
        |=> !queryResult[g] && !press_latched[g])
      else $error("query on clear bit changed state");

    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
      press_query[g] && press_latched[g] && pressSeen[g]
        |=> queryResult[g] && press_latched[g])
      else $error("new press lost to a clear");

    result_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !press_query[g] |=> !queryResult[g])
      else $error("query answer without a query");

    result_source_a: assert property (@(posedge clk) disable iff (sys_rst)
      queryResult[g] |-> $past(press_latched[g]))
      else $error("query answer from a clear bit");
  end : g_btnChk

  run_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    runStopLevel == $past(rsMeta_reg))
    else $error("switch level not passed through");

  btn_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
    btnSync_reg == $past(btnMeta_reg))
    else $error("button pins not passed through the synchroniser");

  tick_only_a: assert property (@(posedge clk) disable iff (sys_rst)
    !debounce_tick_handler |=> (press_latched & ~$past(press_latched)) == BTN_NONE)
    else $error("press latched between ticks");

  scan_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyPress |=> !scanEnabled)
    else $error("scanning not suspended after press");

  preset_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg <= CNT_PRESET)
    else $error("counter above its preset");

  rescan_a: assert property (@(posedge clk) disable iff (sys_rst)
    debounce_tick_handler && cnt_reg == CNT_ONE |=> scanEnabled)
    else $error("scanning not resumed at zero");

  blank_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(scanEnabled) |-> blankLen_reg == PRESET_TICKS * TICK_CYCLES)
    else $error("blanking interval has the wrong length");

  press_cover: cover property (@(posedge clk) disable iff (sys_rst) anyPress);
  query_cover: cover property (@(posedge clk) disable iff (sys_rst) |clearHit);
  rescan_cover: cover property (@(posedge clk) disable iff (sys_rst)
    cnt_reg == CNT_ONE && debounce_tick_handler);
  pair_cover: cover property (@(posedge clk) disable iff (sys_rst)
    $countones(pressSeen) > 1);
  set_clear_cover: cover property (@(posedge clk) disable iff (sys_rst)
    |(pressSeen & clearHit));

endmodule : button_debounce_latch

// >>> tb/button_model.sv
`timescale 1ns/1ns
module button_model
(
  input  wire logic             clk,        // System clock.
  input  wire button_pkg::btn_t pressed,    // Button held, high when pressed.
  output button_pkg::btn_t      buttonPin_n // Bouncing contact, low when pressed.
);
  import button_pkg::*;

  btn_t held = BTN_NONE;
  btn_t chg = BTN_NONE;
  int   bounce = 0;
  // A changed contact chatters for some cycles before it settles.
  always @(negedge clk)
  begin
    if (pressed !== held)
    begin
      chg = pressed ^ held;
      held = pressed;
      bounce = 6;
    end
    buttonPin_n = ~held ^ (bounce > 0 ? btn_t'($urandom) & chg : BTN_NONE);
    if (bounce > 0) bounce--;
  end
endmodule : button_model

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import button_pkg::*;
  localparam int TC = 4;
  localparam int BL = PRESET_TICKS * TC;
  logic clk = 0, sys_rst = 1, run_stop_input = 1, runStopLevel, scanEnabled;
  btn_t pressed = BTN_NONE, press_query = BTN_NONE, pins, queryResult, press_latched;
  int   fail_count = 0, checks = 0, cycles = 0, n, b, b2, t0, c;
  always #4 clk = ~clk;
  button_model model (.clk(clk), .pressed(pressed), .buttonPin_n(pins));
  button_debounce_latch #(.TICK_CYCLES(TC)) uut (.clk(clk), .sys_rst(sys_rst),
    .run_stop_input(run_stop_input), .buttonPin_n(pins), .press_query(press_query),
    .runStopLevel(runStopLevel), .queryResult(queryResult),
    .press_latched(press_latched), .scanEnabled(scanEnabled));
  function automatic btn_t oneHot(int i);
    return btn_t'(1) << i;
  endfunction : oneHot
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic query(int i, logic exp);
    @(negedge clk) press_query = oneHot(i);
    @(negedge clk) press_query = BTN_NONE;
    check("queryResult", 8'(exp ? oneHot(i) : BTN_NONE), 8'(queryResult));
    check("cleared", 8'H0, 8'(press_latched[i]));
    @(negedge clk) check("queryEnd", 8'H0, 8'(queryResult));
  endtask : query
  task automatic resetCheck;
    check("reset latched", 8'H0, 8'(press_latched));
    check("reset scan", 8'H1, 8'(scanEnabled));
    check("reset result", 8'H0, 8'(queryResult));
    check("reset level", 8'H1, 8'(runStopLevel));
  endtask : resetCheck
  task automatic waitScan(logic lvl);
    for (c = 0; c < BL + 2 * TC + 20 && scanEnabled !== lvl; c++) @(negedge clk);
    check("scanEnabled", 8'(lvl), 8'(scanEnabled));
  endtask : waitScan
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'HD266));
    repeat (3) @(negedge clk);
    sys_rst = 0;
    resetCheck();
    for (n = 0; n < 6; n++)
    begin
      b = $urandom_range(NUM_BUTTONS - 1);
      b2 = (b + 1) % NUM_BUTTONS;
      run_stop_input = 1'($urandom_range(1));
      repeat (3) @(negedge clk);
      check("runStopLevel", 8'(run_stop_input), 8'(runStopLevel));
      pressed[b] = 1;
      waitScan(0);
      t0 = cycles;
      check("latched", 8'(btn_t'(1) << b), 8'(press_latched));
      pressed[b] = 0;
      pressed[b2] = 1;
      query(b, 1);
      query(b, 0);
      waitScan(1);
      check("blank", 8'H1, 8'(cycles - t0 >= BL - TC && cycles - t0 <= BL + TC));
      check("ignored", 8'H0, 8'(press_latched));
      waitScan(0);
      check("later", 8'(btn_t'(1) << b2), 8'(press_latched));
      pressed = BTN_NONE;
      query(b2, 1);
      waitScan(1);
    end
    // A clear and a new press at one scan tick, with two new buttons at once.
    pressed = oneHot(1);
    waitScan(0);
    check("held", 8'(oneHot(1)), 8'(press_latched));
    pressed = oneHot(0) | oneHot(1) | oneHot(3);
    waitScan(1);
    repeat (3) @(negedge clk);
    press_query = oneHot(1);
    @(negedge clk) press_query = BTN_NONE;
    check("setWins", 8'(oneHot(1)), 8'(queryResult));
    check("pair", 8'(pressed), 8'(press_latched));
    check("reblank", 8'H0, 8'(scanEnabled));
    pressed = BTN_NONE;
    query(0, 1);
    query(1, 1);
    query(3, 1);
    query(2, 0);
    waitScan(1);
    // Reset in mid-run while a press is latched and scanning is blanked.
    pressed = oneHot(2);
    waitScan(0);
    check("held2", 8'(oneHot(2)), 8'(press_latched));
    pressed = BTN_NONE;
    repeat (10) @(negedge clk);
    sys_rst = 1;
    repeat (3) @(negedge clk);
    sys_rst = 0;
    resetCheck();
    query(2, 0);
    results();
  end
endmodule : tb_top
